//--- common/nv_wait_defines.svh
`ifndef NV_WAIT_DEFINES_SVH
`define NV_WAIT_DEFINES_SVH

// Register byte addresses on the APB bus
`define ADDR_FLASH_BANK_WAIT  12'h000
`define ADDR_OTP_WAIT         12'h004
`define ADDR_ACCESS_STATUS    12'h008

// Field positions
`define PAGED_LSB             8
`define PAGED_MSB             11
`define RANDOM_LSB            0
`define RANDOM_MSB            3
`define OTP_LSB               0
`define OTP_MSB               4

// Reset values
`define PAGED_RESET           4'hF
`define RANDOM_RESET          4'hF
`define OTP_RESET             5'h1F

// Status register bits
`define BUSY_BIT              0
`define BLOCKED_BIT           1

// Timing counts
`define WAIT_LAST             5'h01

`endif

//--- common/nv_wait_pkg.sv
package nv_wait_pkg;

  typedef enum logic [1:0] {
    ARR_FLASH_PAGED  = 2'h0,
    ARR_FLASH_RANDOM = 2'h1,
    ARR_OTP          = 2'h2
  } array_sel_e;

  typedef struct packed {
    logic       valid;
    array_sel_e sel;
    logic       secure_block;
  } fetch_req_s;

  typedef struct packed {
    logic        ready;
    logic        zeroed;
    logic [15:0] data;
  } fetch_rsp_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } acc_state_e;

endpackage

//--- verification/fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
  input  wire logic                    core_clk,
  input  wire nv_wait_pkg::fetch_rsp_s fetch_rsp,
  output nv_wait_pkg::fetch_req_s      fetch_req,
  output logic [15:0]                  array_rdata
);
  initial fetch_req = '0;
  initial array_rdata = 16'h0;
  // Fresh word each cycle, so a capture on the wrong edge shows
  always @(posedge core_clk) array_rdata <= array_rdata + 16'h1357;
  task automatic fetch(input logic [1:0] s, input logic sb, output int k, output logic ok);
    logic [15:0] d;
    k = 0;
    d = 16'h0;
    @(posedge core_clk);
    fetch_req <= '{1'b1, nv_wait_pkg::array_sel_e'(s), sb};
    do begin
      @(posedge core_clk);
      k++;
      // The answer carries the word that stood at the edge before ready showed
      if (!fetch_rsp.ready) begin
        d = array_rdata;
      end
    end while (!fetch_rsp.ready && k < 40);
    fetch_req.valid <= 1'b0;
    ok = fetch_rsp.data === (sb ? 16'h0 : d) && fetch_rsp.zeroed === sb;
  endtask
endmodule
`default_nettype wire

//--- verification/nv_wait_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module nv_wait_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic regs_secured,
  input wire nv_wait_pkg::fetch_req_s fetch_req,
  input wire nv_wait_pkg::fetch_rsp_s fetch_rsp,
  input wire logic array_strobe
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence take_s;
    $rose(fetch_req.valid);
  endsequence
  sequence rd_s;
    psel && penable && pready && !pwrite;
  endsequence
  bank_rsvd_a: assert property (rd_s ##0 paddr == 12'h000 |->
    prdata[31:12] == 20'h0 && prdata[7:4] == 4'h0) else $error("bank reserved bits set");
  otp_rsvd_a: assert property (rd_s ##0 paddr == 12'h004 |->
    prdata[31:5] == 27'h0) else $error("otp reserved bits set");
  secured_zero_a: assert property (rd_s ##0 regs_secured && paddr < 12'h008 |->
    prdata == 32'h0) else $error("secured read not zero");
  quick_answer_a: assert property (psel && !penable && regs_secured |=> pready)
    else $error("secured access stalled");
  secure_fast_a: assert property (take_s ##0 fetch_req.secure_block |->
    ##1 fetch_rsp.ready && fetch_rsp.zeroed) else $error("blocked fetch not answered");
  no_early_a: assert property (fetch_rsp.ready |-> $past(fetch_req.valid))
    else $error("fetch answered without request");
  strobe_pulse_a: assert property (take_s ##0 !fetch_req.secure_block |=> array_strobe)
    else $error("array strobe missing");
  ready_pulse_a: assert property (fetch_rsp.ready |=> !fetch_rsp.ready)
    else $error("fetch ready not a pulse");
  zero_data_a: assert property (fetch_rsp.zeroed |->
    fetch_rsp.ready && fetch_rsp.data == 16'h0) else $error("zeroed answer bad");
endmodule
bind nv_wait_ctrl nv_wait_asserts chk (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .regs_secured, .fetch_req, .fetch_rsp, .array_strobe);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, protected_write_unlock = 1'b0, regs_secured = 1'b0;
  logic pready, pslverr, ok, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] array_rdata;
  nv_wait_pkg::fetch_req_s fetch_req;
  nv_wait_pkg::fetch_rsp_s fetch_rsp;
  int errors = 0, samples_checked = 0, k;
  always #20 core_clk = ~core_clk;
  nv_wait_ctrl uut (.core_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .protected_write_unlock, .regs_secured, .fetch_req,
    .array_rdata, .fetch_rsp, .array_strobe());
  fetch_model cpu (.core_clk, .fetch_rsp, .fetch_req, .array_rdata);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic fchk(input logic [1:0] s, input logic sb, input int e);
    cpu.fetch(s, sb, k, ok);
    `CHK(k, e)
    `CHK(ok, 1'b1)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rchk(12'h000, 32'hF0F);
    rchk(12'h004, 32'h1F);
    apb(1'b1, 12'h000, 32'h101);
    rchk(12'h000, 32'hF0F);
    rchk(12'h008, 32'h2);
    protected_write_unlock <= 1'b1;
    apb(1'b1, 12'h000, 32'hFFFFF5F2);
    rchk(12'h000, 32'h502);
    apb(1'b1, 12'h004, 32'hFFFFFFE3);
    rchk(12'h004, 32'h3);
    fchk(2'h0, 1'b0, 7);
    fchk(2'h1, 1'b0, 4);
    fchk(2'h2, 1'b0, 5);
    apb(1'b1, 12'h000, 32'hF);
    apb(1'b1, 12'h004, 32'h1F);
    fchk(2'h0, 1'b0, 2);
    fchk(2'h1, 1'b0, 17);
    fork
      cpu.fetch(2'h1, 1'b0, k, ok);
      begin
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (5) @(posedge core_clk);
        clk_en <= 1'b1;
      end
    join
    `CHK(k, 22)
    `CHK(ok, 1'b1)
    fchk(2'h2, 1'b0, 33);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    regs_secured <= 1'b1;
    apb(1'b1, 12'h000, 32'h303);
    rchk(12'h000, 32'h0);
    fchk(2'h2, 1'b1, 2);
    regs_secured <= 1'b0;
    rchk(12'h000, 32'hF);
    end_of_test();
  end
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verilog/nv_wait_ctrl.sv
// Function
// - Paged flash read wait count comes from bits 11..8 of flash wait register.
// - Paged value 0 gives one clock; each step adds one; reset all ones.
// - Random flash read wait count comes from bits 3..0 of flash wait register.
// - Random value N gives N plus one clocks; reset all ones, sixteen clocks.
// - Paged above random is neither checked nor corrected; fields used as written.
// - OTP read wait count comes from bits 4..0 of OTP wait register.
// - OTP reads have no paged mode; one OTP setting for every access.
// - OTP value N gives N plus one clocks, up to thirty-two clocks.
// - The same fields govern mask ROM blocks that replace flash or OTP.
// - Both wait registers accept writes only while write unlock is active.
// - Both wait registers are guarded by code security; software follows change procedure.
// - Secured unauthorized reads return zero without stalling.
`timescale 1ns/10ps
`default_nettype none
`include "nv_wait_defines.svh"

module nv_wait_ctrl (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    protected_write_unlock,
  input  wire logic                    regs_secured,
  input  wire nv_wait_pkg::fetch_req_s fetch_req,
  input  wire logic [15:0]             array_rdata,
  output nv_wait_pkg::fetch_rsp_s      fetch_rsp,
  output logic                         array_strobe
);

  // Register group
  logic [3:0]  paged_q;
  logic [3:0]  paged_d;
  logic [3:0]  random_q;
  logic [3:0]  random_d;
  logic [4:0]  otp_q;
  logic [4:0]  otp_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        blocked_wr_q;
  logic        blocked_wr_d;

  // Access group
  nv_wait_pkg::acc_state_e state_q;
  nv_wait_pkg::acc_state_e state_d;
  logic [4:0]              cnt_q;
  logic [4:0]              cnt_d;
  nv_wait_pkg::fetch_rsp_s rsp_q;
  nv_wait_pkg::fetch_rsp_s rsp_d;
  logic                    strobe_q;
  logic                    strobe_d;

  // Bus decode
  logic        setup;
  logic        commit;
  logic        hit_bank;
  logic        hit_otp;
  logic        hit_status;
  logic        hit_any;
  logic        wr_ok;
  logic        wr_bank;
  logic        wr_otp;
  logic        wr_blocked;
  logic        clr_blocked;

  // Read side
  logic        busy;
  logic [31:0] bank_mask;
  logic [31:0] otp_mask;
  logic [31:0] bank_word;
  logic [31:0] otp_word;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // Read data is staged at setup so it stands through the whole access phase
  assign setup      = psel && !penable && !pready_q;
  // Writes land only at the edge that ends the access phase
  assign commit     = psel && penable && pready_q && pwrite;
  assign hit_bank   = (paddr == `ADDR_FLASH_BANK_WAIT);
  assign hit_otp    = (paddr == `ADDR_OTP_WAIT);
  assign hit_status = (paddr == `ADDR_ACCESS_STATUS);
  assign hit_any    = hit_bank || hit_otp || hit_status;

  // Secured or locked registers drop writes and set the blocked status bit
  assign wr_ok       = protected_write_unlock && !regs_secured;
  assign wr_bank     = commit && hit_bank && wr_ok;
  assign wr_otp      = commit && hit_otp && wr_ok;
  assign wr_blocked  = commit && (hit_bank || hit_otp) && !wr_ok;
  assign clr_blocked = commit && hit_status && pwdata[`BLOCKED_BIT];
  assign busy        = (state_q == nv_wait_pkg::ST_WAIT);

  // Reserved bits are cut per bit, so they read zero whatever a field holds
  for (genvar i = 0; i < 32; i++) begin : g_mask
    assign bank_mask[i] = ((i >= `PAGED_LSB) && (i <= `PAGED_MSB)) ||
                          ((i >= `RANDOM_LSB) && (i <= `RANDOM_MSB));
    assign otp_mask[i]  = (i >= `OTP_LSB) && (i <= `OTP_MSB);
  end

  always_comb begin
    bank_word                          = 32'h0000_0000;
    bank_word[`PAGED_MSB:`PAGED_LSB]   = paged_q;
    bank_word[`RANDOM_MSB:`RANDOM_LSB] = random_q;
    bank_word                          = bank_word & bank_mask;
  end

  always_comb begin
    otp_word                    = 32'h0000_0000;
    otp_word[`OTP_MSB:`OTP_LSB] = otp_q;
    otp_word                    = otp_word & otp_mask;
  end

  // Status stays readable while secured so software can see a blocked write
  always_comb begin
    status_word               = 32'h0000_0000;
    status_word[`BUSY_BIT]    = busy;
    status_word[`BLOCKED_BIT] = blocked_wr_q;
  end

  // Secured wait registers read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!pwrite) begin
      if (hit_bank) begin
        if (!regs_secured) begin
          rd_word = bank_word;
        end
      end else if (hit_otp) begin
        if (!regs_secured) begin
          rd_word = otp_word;
        end
      end else if (hit_status) begin
        rd_word = status_word;
      end
    end
  end

  always_comb begin
    paged_d      = paged_q;
    random_d     = random_q;
    otp_d        = otp_q;
    prdata_d     = prdata_q;
    pready_d     = 1'b0;
    pslverr_d    = 1'b0;
    blocked_wr_d = blocked_wr_q;
    // Zero wait states: the answer stands in the cycle after setup
    if (setup) begin
      pready_d  = 1'b1;
      prdata_d  = rd_word;
      pslverr_d = !hit_any;
    end
    if (wr_bank) begin
      // No cross check between fields
      paged_d  = pwdata[`PAGED_MSB:`PAGED_LSB];
      random_d = pwdata[`RANDOM_MSB:`RANDOM_LSB];
    end
    if (wr_otp) begin
      otp_d = pwdata[`OTP_MSB:`OTP_LSB];
    end
    // Set comes after clear so a blocked write is never lost
    if (clr_blocked) begin
      blocked_wr_d = 1'b0;
    end
    if (wr_blocked) begin
      blocked_wr_d = 1'b1;
    end
  end

  // Low clk_en freezes every register, the bus answer included
  always_ff @(posedge core_clk) begin
    if (reset) begin
      paged_q      <= `PAGED_RESET;
      random_q     <= `RANDOM_RESET;
      otp_q        <= `OTP_RESET;
      prdata_q     <= 32'h0000_0000;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      blocked_wr_q <= 1'b0;
    end else if (clk_en) begin
      paged_q      <= paged_d;
      random_q     <= random_d;
      otp_q        <= otp_d;
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
      blocked_wr_q <= blocked_wr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Wait count selected per array; ROM replacements use the same fields
  logic [4:0] wait_sel;
  always_comb begin
    wait_sel = otp_q;
    case (fetch_req.sel)
      nv_wait_pkg::ARR_FLASH_PAGED: begin
        wait_sel = {1'b0, paged_q};
      end
      nv_wait_pkg::ARR_FLASH_RANDOM: begin
        wait_sel = {1'b0, random_q};
      end
      nv_wait_pkg::ARR_OTP: begin
        wait_sel = otp_q;
      end
      default: begin
        wait_sel = otp_q;
      end
    endcase
  end

  // Fetch decode
  logic take;
  logic take_blocked;
  logic take_array;
  logic no_wait;
  logic expire;
  // A request still up while its answer shows is the one just served
  assign take         = fetch_req.valid && !rsp_q.ready;
  assign take_blocked = take && fetch_req.secure_block;
  assign take_array   = take && !fetch_req.secure_block;
  assign no_wait      = (wait_sel == 5'h00);
  assign expire       = (cnt_q == `WAIT_LAST);

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    rsp_d.ready  = 1'b0;
    rsp_d.zeroed = 1'b0;
    rsp_d.data   = 16'h0000;
    strobe_d     = 1'b0;
    case (state_q)
      nv_wait_pkg::ST_IDLE: begin
        if (take_blocked) begin
          // Blocked read answers at once with zero, no stall
          rsp_d.ready  = 1'b1;
          rsp_d.zeroed = 1'b1;
        end else if (take_array) begin
          strobe_d = 1'b1;
          if (no_wait) begin
            // Zero waits answer from idle: one clock in all
            rsp_d.ready = 1'b1;
            rsp_d.data  = array_rdata;
          end else begin
            cnt_d   = wait_sel;
            state_d = nv_wait_pkg::ST_WAIT;
          end
        end
      end

      nv_wait_pkg::ST_WAIT: begin
        // A zero random or OTP value is not refused; it acts as one clock
        if (expire) begin
          rsp_d.ready = 1'b1;
          rsp_d.data  = array_rdata;
          state_d     = nv_wait_pkg::ST_IDLE;
        end
        // Counting down keeps the end test on a fixed value
        cnt_d = cnt_q - 5'h01;
      end

      default: begin
        state_d = nv_wait_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q  <= nv_wait_pkg::ST_IDLE;
      cnt_q    <= 5'h00;
      rsp_q    <= '0;
      strobe_q <= 1'b0;
    end else if (clk_en) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      rsp_q    <= rsp_d;
      strobe_q <= strobe_d;
    end
  end

  assign fetch_rsp    = rsp_q;
  assign array_strobe = strobe_q;

endmodule
`default_nettype wire
